// [hw/sut_bit_timer.v]
// bit-interval enable generator for the serial transceiver
// assumes the divisor is stable while counting; a reload restarts the interval
module sut_bit_timer #(
  parameter DIV_W = 15
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire restart,
  input wire [DIV_W-1:0] divisor,
  // enable out
  output reg tick_q
);
  reg [DIV_W-1:0] cnt_q;
  // =====================================================================
  // divisor n gives n+1 cycles between ticks
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (restart)
    begin
      // primed one step in, so the first tick is n+1 cycles away like every later one
      if (divisor == {DIV_W{1'b0}})
      begin
        cnt_q <= {DIV_W{1'b0}};
        tick_q <= 1'b1;
      end
      else
      begin
        cnt_q <= divisor - {{(DIV_W-1){1'b0}}, 1'b1};
        tick_q <= 1'b0;
      end
    end
    else if (cnt_q == {DIV_W{1'b0}})
    begin
      cnt_q <= divisor;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule // sut_bit_timer

// [hw/sut_uart.v]
// serial transceiver: receive status, set/clear control, transmit holding and shifter
// assumes an apb master on pclk; rxd is synchronous to pclk
// Behaviour
// RULE_01: overrun flag bit 15 sets when a character lands before the previous was collected
// RULE_02: status bit 14 mirrors the receive-full request flag
// RULE_03: software clears receive-full request bit 11 after collecting data
// RULE_04: bit 13 shows holding register empty; request raised when it empties
// RULE_05: bit 12 set only when shifter and holding register are both drained
// RULE_06: bit 11 reads the receive pin directly; bit 10 reads zero
// RULE_07: nine-bit mode: ninth bit at 8, stop at 9; eight-bit mode stop at 8
// RULE_08: low eight received bits sit in bits 7-0, uninverted
// RULE_09: control write sets ones when bit 15 is 1, else clears them
// RULE_10: control bit 11 forces the transmit pin low
// RULE_11: transmit uses receive bit period and starts right after holding write
// RULE_12: holding word copies into shifter; then holding frees and empty request fires
// RULE_13: one bit per interval shifted out, least significant first
// RULE_14: shifter stops when only a 1 remains in the out position
// RULE_15: one start bit is emitted automatically before data bit 0
// RULE_16: software writes ones above data bits as stop bits
// RULE_17: an all-zero holding write starts nothing
// RULE_18: holding register is 16 bits wide and write-only
// RULE_19: divisor n gives n+1 clocks between samples and between bits
// RULE_20: baud bit 15 picks nine or eight data bits; start, data, stop expected
// RULE_21: transmit pin idles high when not shifting and no break
`include "sut_defines.vh"
module sut_uart #(
  parameter DIV_W = 15
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial pins
  input wire rxd,
  output reg txd_q
);
  // =====================================================================
  // state
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  reg [15:0] baud_q;
  reg [15:0] ctrl_q;
  reg [15:0] hold_q;
  reg hold_full_q;
  reg [15:0] sh_q;
  reg sh_busy_q;
  reg start_q;
  reg rbf_q;
  reg ovr_q;
  reg tbe_req_q;
  reg [9:0] rxbuf_q;
  reg [9:0] rxsh_q;
  reg [3:0] rxcnt_q;
  reg [1:0] rxst_q;
  reg [DIV_W-1:0] rxdiv_q;
  wire tx_tick;
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_rs = paddr == `SUT_OFS_RXSTAT;
  wire hit_ct = paddr == `SUT_OFS_CTRL;
  wire hit_tx = paddr == `SUT_OFS_TXHOLD;
  wire hit_bd = paddr == `SUT_OFS_BAUD;
  wire hit_iq = paddr == `SUT_OFS_IRQ;
  wire hit_any = hit_rs | hit_ct | hit_tx | hit_bd | hit_iq;
  wire nine = baud_q[`SUT_BD_NINE];
  wire [DIV_W-1:0] divisor = baud_q[DIV_W-1:0]; // [RULE_19]
  wire hold_wr = wr && hit_tx && (pwdata[15:0] != 16'h0000); // [RULE_17]
  wire sh_done = (sh_q[15:1] == 15'h0000); // [RULE_14]
  wire tx_load = hold_full_q && !sh_busy_q; // [RULE_12]
  wire rx_done;
  reg [15:0] rx_status;
  reg [15:0] irq_view;
  // =====================================================================
  // apb: zero wait states, error on unmapped addresses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      // unaligned or unmapped addresses miss every exact decode and are refused
      pslverr <= setup && !hit_any;
      if (setup && !pwrite && hit_rs)
        prdata <= {16'h0000, rx_status};
      else if (setup && !pwrite && hit_iq)
        prdata <= {16'h0000, irq_view};
      else if (setup && !pwrite && hit_ct)
        prdata <= {16'h0000, ctrl_q};
      else
        prdata <= 32'h00000000;
    end
  end
  wire wr_take = wr && pready;
  // =====================================================================
  // control and baud registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `SUT_CTRL_RST;
      baud_q <= `SUT_BAUD_RST;
    end
    else
    begin
      if (wr_take && hit_ct)
      begin
        if (pwdata[`SUT_CT_SETCLR])
          ctrl_q <= ctrl_q | {1'b0, pwdata[14:0]}; // [RULE_09]
        else
          ctrl_q <= ctrl_q & ~{1'b0, pwdata[14:0]}; // [RULE_09]
      end
      if (wr_take && hit_bd)
        baud_q <= pwdata[15:0]; // [RULE_20]
    end
  end
  // =====================================================================
  // transmit holding register and shifter
  // a write while the holding word still waits replaces it; software polls bit 13 first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_q <= 16'h0000;
      hold_full_q <= 1'b0;
      sh_q <= 16'h0000;
      sh_busy_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      if (hold_wr && pready)
      begin
        hold_q <= pwdata[15:0]; // [RULE_18]
        hold_full_q <= 1'b1; // [RULE_11]
      end
      else if (tx_load)
        hold_full_q <= 1'b0; // [RULE_12]
      if (tx_load)
      begin
        sh_q <= hold_q; // [RULE_12]
        sh_busy_q <= 1'b1;
        start_q <= 1'b1; // [RULE_15]
      end
      else if (sh_busy_q && tx_tick)
      begin
        if (start_q)
          start_q <= 1'b0;
        else if (sh_done)
          sh_busy_q <= 1'b0; // [RULE_14]
        else
          sh_q <= {1'b0, sh_q[15:1]}; // [RULE_13]
      end
    end
  end
  // bit timer restarts at each load so the start bit gets a full interval
  sut_bit_timer #(
    .DIV_W(DIV_W)
  ) u_tx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(tx_load),
    .divisor(divisor),
    .tick_q(tx_tick)
  );
  // =====================================================================
  // transmit pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txd_q <= 1'b1;
    else if (ctrl_q[`SUT_CT_BRK])
      txd_q <= 1'b0; // [RULE_10]
    else if (sh_busy_q && start_q)
      txd_q <= 1'b0; // [RULE_15]
    else if (sh_busy_q)
      txd_q <= sh_q[0]; // [RULE_13]
    else
      txd_q <= 1'b1; // [RULE_21]
  end
  // =====================================================================
  // receiver: sample mid-bit, n+1 clocks per bit
  wire [3:0] rx_bits = nine ? `SUT_RX_LEN9 : `SUT_RX_LEN8; // data plus stop
  wire [DIV_W-1:0] half_div = {1'b0, divisor[DIV_W-1:1]};
  assign rx_done = (rxst_q == RX_DATA) && (rxdiv_q == {DIV_W{1'b0}})
    && (rxcnt_q == rx_bits - 4'h1);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxst_q <= RX_IDLE;
      rxdiv_q <= {DIV_W{1'b0}};
      rxcnt_q <= 4'h0;
      rxsh_q <= 10'h000;
    end
    else
    begin
      case (rxst_q)
        RX_IDLE:
        begin
          if (!rxd)
          begin
            rxst_q <= RX_START;
            rxdiv_q <= half_div;
          end
        end
        RX_START:
        begin
          if (rxdiv_q != {DIV_W{1'b0}})
            rxdiv_q <= rxdiv_q - {{(DIV_W-1){1'b0}}, 1'b1};
          else if (rxd)
            rxst_q <= RX_IDLE; // glitch, not a start bit
          else
          begin
            rxst_q <= RX_DATA;
            rxdiv_q <= divisor; // [RULE_19]
            rxcnt_q <= 4'h0;
          end
        end
        RX_DATA:
        begin
          if (rxdiv_q != {DIV_W{1'b0}})
            rxdiv_q <= rxdiv_q - {{(DIV_W-1){1'b0}}, 1'b1};
          else
          begin
            rxdiv_q <= divisor;
            rxsh_q[rxcnt_q] <= rxd; // [RULE_20]
            rxcnt_q <= rxcnt_q + 4'h1;
            if (rx_done)
              rxst_q <= RX_IDLE;
          end
        end
        default:
          rxst_q <= RX_IDLE;
      endcase
    end
  end
  // =====================================================================
  // receive buffer and request flags; hardware set wins over software clear
  wire irq_wr = wr_take && hit_iq;
  wire irq_setop = pwdata[`SUT_CT_SETCLR];
  // set writes to the request register are ignored; only clears act
  wire rbf_clr = irq_wr && !irq_setop && pwdata[`SUT_IRQ_RBF];
  wire tbe_clr = irq_wr && !irq_setop && pwdata[`SUT_IRQ_TBE];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxbuf_q <= 10'h000;
      rbf_q <= 1'b0;
      ovr_q <= 1'b0;
      tbe_req_q <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        rxbuf_q <= nine ? {rxd, rxsh_q[8:0]} : {1'b0, rxd, rxsh_q[7:0]}; // [RULE_07]
        rbf_q <= 1'b1;
        if (rbf_q)
          ovr_q <= 1'b1; // [RULE_01]
      end
      else if (rbf_clr)
      begin
        rbf_q <= 1'b0; // [RULE_03]
        ovr_q <= 1'b0;
      end
      if (tx_load)
        tbe_req_q <= 1'b1; // [RULE_04]
      else if (tbe_clr)
        tbe_req_q <= 1'b0;
    end
  end
  // =====================================================================
  // read views, field by field; unused bits such as bit 10 stay zero
  always @*
  begin
    rx_status = 16'h0000; // [RULE_06]
    rx_status[`SUT_RS_OVR] = ovr_q; // [RULE_01]
    rx_status[`SUT_RS_RBF] = rbf_q; // [RULE_02]
    rx_status[`SUT_RS_TBE] = !hold_full_q; // [RULE_04]
    rx_status[`SUT_RS_TRANSMIT_SHIFTER_IDLE] = !hold_full_q && !sh_busy_q; // [RULE_05]
    rx_status[`SUT_RS_RXD] = rxd; // [RULE_06]
    rx_status[`SUT_RS_STP9] = rxbuf_q[9]; // [RULE_07]
    rx_status[`SUT_RS_B8] = rxbuf_q[8]; // [RULE_07]
    rx_status[7:0] = rxbuf_q[7:0]; // [RULE_08]
  end
  always @*
  begin
    irq_view = 16'h0000;
    irq_view[`SUT_IRQ_OVR] = ovr_q;
    irq_view[`SUT_IRQ_RBF] = rbf_q;
    irq_view[`SUT_IRQ_TBE] = tbe_req_q;
  end
endmodule // sut_uart

// [pkg/sut_defines.vh]
// constants for the serial transceiver block: register offsets, field positions, timing
// assumes inclusion by bare name from the design files
`ifndef SUT_DEFINES_VH
`define SUT_DEFINES_VH
// =====================================================================
// register byte offsets on the apb slave
`define SUT_OFS_RXSTAT 12'h000
`define SUT_OFS_CTRL 12'h004
`define SUT_OFS_TXHOLD 12'h008
`define SUT_OFS_BAUD 12'h00C
`define SUT_OFS_IRQ 12'h010
// =====================================================================
// receive status fields
`define SUT_RS_OVR 15
`define SUT_RS_RBF 14
`define SUT_RS_TBE 13
`define SUT_RS_TRANSMIT_SHIFTER_IDLE 12
`define SUT_RS_RXD 11
`define SUT_RS_STP9 9
`define SUT_RS_B8 8
// control fields
`define SUT_CT_SETCLR 15
`define SUT_CT_BRK 11
// baud register fields
`define SUT_BD_NINE 15
`define SUT_BD_DIV_MSB 14
// receive frame length after the start bit: data bits plus one stop bit
`define SUT_RX_LEN8 4'h9
`define SUT_RX_LEN9 4'hA
// interrupt request register fields
`define SUT_IRQ_RBF 11
`define SUT_IRQ_TBE 0
`define SUT_IRQ_OVR 15
// =====================================================================
// reset values
`define SUT_BAUD_RST 16'h0173
`define SUT_CTRL_RST 16'h0000
`endif

// [tb/sut_peer.sv]
// far-side serial peer: sends frames on rxd, decodes frames on txd_q
// assumes 8 data bits on transmit; frames with a low stop bit are dropped
// =====================================================================
// peer
module sut_peer #(
  parameter int BIT = 4
) (
  // clock
  input wire logic pclk,
  // serial lines
  input wire logic txd_q,
  output logic rxd,
  // decoded frame
  output logic [8:0] got,
  output logic got_v
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh;
  initial
  begin
    rxd = 1'b1;
    got = 9'h000;
    got_v = 1'b0;
  end
  task automatic send(input logic [8:0] d, input logic nine);
    rxd <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < 8 + nine; i++)
    begin
      rxd <= d[i];
      repeat (BIT) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask
  // sample mid-bit; re-arm only after the line is high, so a break is one frame
  always
  begin
    @(posedge pclk);
    if (txd_q === 1'b0)
    begin
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT) @(posedge pclk);
        sh[i] = txd_q;
      end
      if (sh[8])
      begin
        got <= sh;
        got_v <= 1'b1;
        @(posedge pclk);
        got_v <= 1'b0;
      end
      while (txd_q !== 1'b1) @(posedge pclk);
    end
  end
endmodule // sut_peer

// [tb/sut_uart_properties.sv]
// port checker for the serial transceiver
// assumes apb requests are held until pready is sampled high
// =====================================================================
// checker
module sut_uart_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial
  input wire logic rxd,
  input wire logic txd_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic brk_q;
  logic ok_q;
  logic [14:0] div_q;
  logic [15:0] low_q;
  wire logic wr = pready && pwrite;
  wire logic rs = pready && !pwrite && paddr == 12'h000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ok_q drops during break so a released break is not taken for a bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brk_q <= 1'b0;
      ok_q <= 1'b0;
      div_q <= 15'h0173;
      low_q <= 16'h0000;
    end
    else
    begin
      if (wr && paddr == 12'h004 && pwdata[11]) brk_q <= pwdata[15];
      if (wr && paddr == 12'h00C) div_q <= pwdata[14:0];
      if (brk_q) ok_q <= 1'b0;
      else if (txd_q) ok_q <= 1'b1;
      low_q <= txd_q ? 16'h0000 : low_q + 16'h0001;
    end
  end
  chk_ready_access: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in access cycle");
  chk_ready_single: assert property (pready |=> !pready) else $error("pready held");
  chk_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  chk_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000
    && !(paddr == 12'h000 && prdata[10])) else $error("unused read bits set");
  chk_break_low: assert property (brk_q && $past(brk_q) |-> !txd_q)
    else $error("break not driving line low");
  chk_bit_period: assert property ($rose(txd_q) && ok_q |->
    low_q % ({1'b0, div_q} + 16'h0001) == 16'h0000) else $error("bit length wrong");
  chk_idle_both: assert property (rs && prdata[12] |-> prdata[13])
    else $error("shifter idle with holding full");
  chk_idle_line: assert property (rs && prdata[12] && !brk_q && !$past(brk_q)
    && !$past(brk_q, 2) |-> txd_q) else $error("idle line not high");
endmodule // sut_uart_props

bind sut_uart sut_uart_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_q(txd_q));

// [tb/sut_uart_tb.sv]
// testbench for the serial transceiver
// assumes wait-free apb answers and a serial peer at the far side
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
// =====================================================================
// bench
module sut_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic txd_q;
  logic [8:0] got;
  logic got_v;
  int errors = 0;
  int total_checks = 0;
  integer seed = 32'ha69c;
  logic [63:0] rd_q[$];
  logic [8:0] tx_q[$];
  logic [63:0] nt;
  logic [8:0] fx;
  logic [31:0] q;
  logic [15:0] r;
  logic slverr;
  always #5 pclk = ~pclk;
  sut_uart dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd_q(txd_q));
  sut_peer #(.BIT(DIV + 1)) peer_u (.pclk(pclk), .txd_q(txd_q), .rxd(rxd), .got(got),
    .got_v(got_v));
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
    input logic [31:0] m, input logic [31:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    if (!w) rd_q.push_back({m, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int k);
    repeat (200)
    begin
      apb(1'b0, 12'h000, 16'h0, 32'h0, 32'h0);
      if (q[k] === 1'b1) break;
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && pwrite === 1'b0)
    begin
      nt = rd_q.pop_front();
      `CHK("prdata", nt[31:0] & nt[63:32], prdata & nt[63:32])
    end
    if (got_v === 1'b1)
    begin
      fx = tx_q.pop_front();
      `CHK("tx frame", fx, got)
    end
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 16'h0, 32'hFFFF, 32'h0);
    apb(1'b1, 12'h00C, 16'(DIV), 32'h0, 32'h0);
    r = 16'($random(seed)) & 16'h77FF;
    apb(1'b1, 12'h004, 16'h8000 | r, 32'h0, 32'h0);
    apb(1'b0, 12'h004, 16'h0, 32'hFFFF, {16'h0, r});
    apb(1'b1, 12'h004, r, 32'h0, 32'h0);
    apb(1'b0, 12'h004, 16'h0, 32'hFFFF, 32'h0);
    apb(1'b1, 12'h004, 16'h8800, 32'h0, 32'h0);
    repeat (50) @(posedge pclk);
    apb(1'b1, 12'h004, 16'h0800, 32'h0, 32'h0);
    apb(1'b0, 12'h100, 16'h0, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      r = {8'h01, 8'($random(seed))};
      tx_q.push_back(r[8:0]);
      apb(1'b1, 12'h008, r, 32'h0, 32'h0);
      `CHK("pslverr", 1'b0, slverr)
      if (i == 1) apb(1'b0, 12'h000, 16'h0, 32'h3000, 32'h0);
      if (i == 1) poll(13);
    end
    poll(12);
    apb(1'b0, 12'h010, 16'h0, 32'h1, 32'h1);
    apb(1'b1, 12'h010, 16'h0001, 32'h0, 32'h0);
    apb(1'b0, 12'h010, 16'h0, 32'h1, 32'h0);
    apb(1'b1, 12'h008, 16'h0, 32'h0, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h000, 16'h0, 32'h3000, 32'h3000);
    r = 16'($random(seed)) & 16'h00FF;
    peer_u.send(r[8:0], 1'b0);
    apb(1'b0, 12'h000, 16'h0, 32'hCDFF, {16'h0, 16'h4900 | r});
    apb(1'b1, 12'h010, 16'h0800, 32'h0, 32'h0);
    apb(1'b0, 12'h000, 16'h0, 32'hC000, 32'h0);
    peer_u.send(9'h055, 1'b0);
    peer_u.send(9'h0AA, 1'b0);
    apb(1'b0, 12'h000, 16'h0, 32'hC0FF, 32'hC0AA);
    apb(1'b0, 12'h010, 16'h0, 32'h8801, 32'h8800);
    apb(1'b1, 12'h010, 16'h0800, 32'h0, 32'h0);
    apb(1'b1, 12'h00C, 16'h8000 | 16'(DIV), 32'h0, 32'h0);
    r = 16'($random(seed)) & 16'h01FF;
    peer_u.send(r[8:0], 1'b1);
    apb(1'b0, 12'h000, 16'h0, 32'h43FF, {16'h0, 16'h4200 | r});
    results();
  end
endmodule // sut_uart_tb
